// ==== zcb_defines.svh ====
`ifndef ZCB_DEFINES_SVH
`define ZCB_DEFINES_SVH

// ----------------------------------------
// instruction word fields (bit 31 is msb)
// ----------------------------------------
`define ZCB_OP_MSB 31
`define ZCB_OP_LSB 26
`define ZCB_D_BIT 25
`define ZCB_CC_MSB 24
`define ZCB_CC_LSB 21
`define ZCB_IMM_MSB 15
`define ZCB_IMM_LSB 0

// ----------------------------------------
// opcodes and condition codes
// ----------------------------------------
`define ZCB_OP_REG 6'h27
`define ZCB_OP_IMM 6'h2F
`define ZCB_CC_EQ 4'h0
`define ZCB_CC_LE 4'h3
`define ZCB_CC_GT 4'h4
`define ZCB_CC_GE 4'h5

// ----------------------------------------
// reset values, steps and cycle costs
// ----------------------------------------
`define ZCB_PC_RESET 32'h0000_0000
`define ZCB_PC_STEP 32'h0000_0004
`define ZCB_LAT_NOT_TAKEN 2'h1
`define ZCB_LAT_DELAYED 2'h2
`define ZCB_LAT_PLAIN 2'h3

`endif

// ==== zcb_pkg.sv ====
`default_nettype none

package zcb_pkg;

   // ----------------------------------------
   // state machine
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      zcb_idle,
      zcb_slot,
      zcb_flush
   } zcb_state_t;

   // ----------------------------------------
   // complete register state of the unit
   // ----------------------------------------
   typedef struct packed
   {
      zcb_state_t state;
      logic [1:0] cnt;
      logic [31:0] target;
      logic [31:0] pc;
      logic pc_load;
      logic taken;
      logic slot_en;
      logic squash;
      logic busy;
      logic done;
      logic bad_op;
   } zcb_regs_t;

endpackage : zcb_pkg

`default_nettype wire

// ==== zcb_branch_unit.sv ====
`include "zcb_defines.svh"
`default_nettype none

module zcb_branch_unit
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,

   // instruction issue
   input wire logic issue_valid,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] pc_current,

   // operand values from the register file
   input wire logic [31:0] source_register_a,
   input wire logic [31:0] offset_register,

   // immediate prefix seen just before this instruction
   input wire logic prefix_valid,
   input wire logic [15:0] prefix_high,

   // program counter update
   output logic pc_load,
   output logic [31:0] pc_value,

   // pipeline control
   output logic busy,
   output logic slot_en,
   output logic squash,
   output logic done,
   output logic taken,
   output logic bad_op
);

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   zcb_pkg::zcb_regs_t state_reg;
   zcb_pkg::zcb_regs_t state_next;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   logic [5:0] op_field;
   logic [3:0] cc_field;
   logic [15:0] imm_field;
   logic wait_slot_flag;
   logic is_reg_form;
   logic is_imm_form;
   logic cc_known;
   logic cond_true;
   logic [31:0] offset_literal;
   logic [31:0] offset_sel;
   logic accept;

   // signed test of one operand against zero
   function automatic logic zcb_cond
   (
      input logic [3:0] cc,
      input logic [31:0] val
   );
      logic is_zero;
      logic is_neg;
      is_zero = (val == 32'h0000_0000);
      is_neg = val[31];
      zcb_cond = 1'b0;
      unique case (cc)
         `ZCB_CC_EQ: zcb_cond = is_zero;
         `ZCB_CC_GE: zcb_cond = !is_neg;
         `ZCB_CC_GT: zcb_cond = !is_neg && !is_zero;
         `ZCB_CC_LE: zcb_cond = is_neg || is_zero;
         default: zcb_cond = 1'b0;
      endcase
   endfunction : zcb_cond

   // ----------------------------------------
   // field extraction and offset choice
   // ----------------------------------------
   always_comb
   begin
      op_field = instr_word[`ZCB_OP_MSB:`ZCB_OP_LSB];
      cc_field = instr_word[`ZCB_CC_MSB:`ZCB_CC_LSB];
      imm_field = instr_word[`ZCB_IMM_MSB:`ZCB_IMM_LSB];
      wait_slot_flag = instr_word[`ZCB_D_BIT];
      is_reg_form = (op_field == `ZCB_OP_REG);
      is_imm_form = (op_field == `ZCB_OP_IMM);
      cc_known = (cc_field == `ZCB_CC_EQ) || (cc_field == `ZCB_CC_GE) ||
                 (cc_field == `ZCB_CC_GT) || (cc_field == `ZCB_CC_LE);
      cond_true = zcb_cond(cc_field, source_register_a);
      if (prefix_valid)
      begin
         offset_literal = {prefix_high, imm_field};
      end
      else
      begin
         offset_literal = {{16{imm_field[15]}}, imm_field};
      end
      if (is_reg_form)
      begin
         offset_sel = offset_register;
      end
      else
      begin
         offset_sel = offset_literal;
      end
      accept = issue_valid && (state_reg.state == zcb_pkg::zcb_idle);
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      state_next.pc_load = 1'b0;
      state_next.done = 1'b0;
      state_next.slot_en = 1'b0;
      state_next.squash = 1'b0;
      state_next.bad_op = 1'b0;
      unique case (state_reg.state)
         zcb_pkg::zcb_idle:
         begin
            state_next.busy = 1'b0;
            if (accept)
            begin
               if (!(is_reg_form || is_imm_form) || !cc_known)
               begin
                  state_next.bad_op = 1'b1;
               end
               else if (!cond_true)
               begin
                  // sequential flow, only pc moves
                  state_next.pc = pc_current + `ZCB_PC_STEP;
                  state_next.pc_load = 1'b1;
                  state_next.done = 1'b1;
                  state_next.taken = 1'b0;
               end
               else if (wait_slot_flag)
               begin
                  state_next.target = pc_current + offset_sel;
                  state_next.state = zcb_pkg::zcb_slot;
                  state_next.cnt = `ZCB_LAT_DELAYED - 2'h1;
                  state_next.busy = 1'b1;
                  state_next.slot_en = 1'b1;
                  state_next.taken = 1'b0;
               end
               else
               begin
                  state_next.target = pc_current + offset_sel;
                  state_next.state = zcb_pkg::zcb_flush;
                  state_next.cnt = `ZCB_LAT_PLAIN - 2'h1;
                  state_next.busy = 1'b1;
                  state_next.squash = 1'b1;
                  state_next.taken = 1'b0;
               end
            end
         end
         zcb_pkg::zcb_slot,
         zcb_pkg::zcb_flush:
         begin
            if (state_reg.cnt == 2'h1)
            begin
               state_next.pc = state_reg.target;
               state_next.pc_load = 1'b1;
               state_next.done = 1'b1;
               state_next.taken = 1'b1;
               state_next.busy = 1'b0;
               state_next.cnt = 2'h0;
               state_next.state = zcb_pkg::zcb_idle;
            end
            else
            begin
               state_next.cnt = state_reg.cnt - 2'h1;
            end
         end
         default:
         begin
            state_next.state = zcb_pkg::zcb_idle;
            state_next.busy = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= '{state: zcb_pkg::zcb_idle, cnt: 2'h0, target: `ZCB_PC_RESET,
                        pc: `ZCB_PC_RESET, pc_load: 1'b0, taken: 1'b0, slot_en: 1'b0,
                        squash: 1'b0, busy: 1'b0, done: 1'b0, bad_op: 1'b0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // outputs straight from the state register
   // ----------------------------------------
   assign pc_load = state_reg.pc_load;
   assign pc_value = state_reg.pc;
   assign busy = state_reg.busy;
   assign slot_en = state_reg.slot_en;
   assign squash = state_reg.squash;
   assign done = state_reg.done;
   assign taken = state_reg.taken;
   assign bad_op = state_reg.bad_op;

endmodule : zcb_branch_unit

`default_nettype wire

// ==== zcb_branch_monitor.sv ====
`default_nettype none

module zcb_branch_monitor
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // issue side
   input wire logic issue_valid,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] pc_current,
   input wire logic [31:0] source_register_a,
   // results
   input wire logic pc_load,
   input wire logic [31:0] pc_value,
   input wire logic busy,
   input wire logic slot_en,
   input wire logic squash,
   input wire logic done,
   input wire logic taken,
   input wire logic bad_op
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic go;
   logic rf;
   logic [3:0] cc;
   assign go = issue_valid && !busy;
   assign rf = instr_word[31:26] == 6'h27;
   assign cc = instr_word[24:21];

   done_load_a: assert property (done |-> pc_load) else $error("done without pc load");
   slot_cost_a: assert property (slot_en |=> done && taken) else $error("delayed cost");
   plain_cost_a: assert property (squash |=> busy ##1 done && taken) else $error("plain cost");
   slot_keep_a: assert property (go && instr_word[25] |=> !squash) else $error("slot squashed");
   plain_drop_a: assert property (go && !instr_word[25] |=> !slot_en) else $error("slot run");
   eq_nonzero_a: assert property (go && instr_word[31:26] == 6'h2F && cc == 4'h0 && source_register_a != 32'h0
      |=> done && !taken) else $error("eq taken on nonzero");
   ge_neg_a: assert property (go && rf && cc == 4'h5 && source_register_a[31]
      |=> done && !taken && pc_value == $past(pc_current) + 32'h4) else $error("ge on negative");
   gt_zero_a: assert property (go && rf && cc == 4'h4 && source_register_a == 32'h0
      |=> done && !taken) else $error("gt taken on zero");
   le_pos_a: assert property (go && rf && cc == 4'h3 && !source_register_a[31] && source_register_a != 32'h0
      |=> !taken) else $error("le taken on positive");

   slot_seen_c: cover property (slot_en);
   squash_seen_c: cover property (squash);
   bad_seen_c: cover property (bad_op);
endmodule : zcb_branch_monitor

bind zcb_branch_unit zcb_branch_monitor mon (.mclk, .rst, .issue_valid, .instr_word, .pc_current,
   .source_register_a, .pc_load, .pc_value, .busy, .slot_en, .squash, .done, .taken, .bad_op);

`default_nettype wire

// ==== zcb_branch_unit_tb.sv ====
`default_nettype none

module zcb_branch_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst = 1, issue_valid = 0, prefix_valid = 0;
   logic [31:0] instr_word = 0, pc_current = 32'h0000_1000, source_register_a = 0, offset_register = 0;
   logic [15:0] prefix_high = 0;
   logic pc_load, busy, slot_en, squash, done, taken, bad_op;
   logic [31:0] pc_value;
   int fail_count = 0, n_compared = 0;

   zcb_branch_unit uut (.mclk(mclk), .rst(rst), .issue_valid(issue_valid), .instr_word(instr_word),
      .pc_current(pc_current), .source_register_a(source_register_a), .offset_register(offset_register),
      .prefix_valid(prefix_valid), .prefix_high(prefix_high), .pc_load(pc_load), .pc_value(pc_value),
      .busy(busy), .slot_en(slot_en), .squash(squash), .done(done), .taken(taken), .bad_op(bad_op));

   initial
   begin
      forever #5 mclk = ~mclk;
   end

   task automatic test_done;
      $display("mismatches %0d compared %0d", fail_count, n_compared);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] enc(input logic [5:0] op, input logic d, input logic [3:0] cc,
      input logic [15:0] imm);
      return {op, d, cc, 5'h00, imm};
   endfunction : enc

   // issue one branch, then check target, outcome and cycle cost
   task automatic br(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b, input logic pv,
      input logic tk, input logic [31:0] tgt, input logic [31:0] cost);
      int n;
      @(negedge mclk);
      issue_valid = 1;
      instr_word = w;
      source_register_a = a;
      offset_register = b;
      prefix_valid = pv;
      prefix_high = 16'h0002;
      @(negedge mclk);
      issue_valid = 0;
      n = 1;
      while (done !== 1'b1 && n < 8)
      begin
         @(negedge mclk);
         n++;
      end
      chk(pc_value, tk ? pc_current + tgt : pc_current + 32'h4);
      chk({31'h0, taken}, {31'h0, tk});
      chk(n, cost);
   endtask : br

   task automatic sc_eq;
      br(enc(6'h27, 0, 4'h0, 0), 0, 32'h0000_0040, 0, 1, 32'h0000_0040, 3);
      br(enc(6'h27, 1, 4'h0, 0), 0, 32'hFFFF_FFF0, 0, 1, 32'hFFFF_FFF0, 2);
      br(enc(6'h2F, 1, 4'h0, 16'hFFF8), 32'h0000_0001, 0, 0, 0, 0, 1);
      br(enc(6'h2F, 0, 4'h0, 16'hFFF8), 0, 0, 0, 1, 32'hFFFF_FFF8, 3);
   endtask : sc_eq

   task automatic sc_ge_gt_le;
      br(enc(6'h27, 0, 4'h5, 0), 32'h8000_0000, 32'h0000_0100, 0, 0, 0, 1);
      br(enc(6'h2F, 1, 4'h5, 16'h0010), 0, 0, 0, 1, 32'h0000_0010, 2);
      br(enc(6'h27, 1, 4'h4, 0), 0, 32'h0000_0100, 0, 0, 0, 1);
      br(enc(6'h2F, 0, 4'h4, 16'h0020), 32'h7FFF_FFFF, 0, 0, 1, 32'h0000_0020, 3);
      br(enc(6'h27, 0, 4'h3, 0), 32'hFFFF_FFFF, 32'h0000_0080, 0, 1, 32'h0000_0080, 3);
      br(enc(6'h27, 1, 4'h3, 0), 32'h0000_0001, 32'h0000_0080, 0, 0, 0, 1);
   endtask : sc_ge_gt_le

   task automatic sc_prefix;
      br(enc(6'h2F, 1, 4'h0, 16'h0010), 0, 0, 1, 1, 32'h0002_0010, 2);
   endtask : sc_prefix

   task automatic sc_bad;
      @(negedge mclk);
      issue_valid = 1;
      instr_word = enc(6'h2F, 0, 4'h1, 0);
      @(negedge mclk);
      issue_valid = 0;
      chk({bad_op, done, pc_load}, 3'b100);
      chk(pc_value, 32'h0002_1010);
   endtask : sc_bad

   initial
   begin
      repeat (10) @(negedge mclk);
      rst = 0;
      sc_eq();
      sc_ge_gt_le();
      sc_prefix();
      sc_bad();
      test_done();
   end

   initial
   begin
      #20000;
      fail_count++;
      test_done();
   end
endmodule : zcb_branch_unit_tb

`default_nettype wire
